// file: core/hsp_port.sv
// Purpose: Serial slave port giving a host access to the register file.
// Assumes: Serial clock idles low and its half period is at least four
//          reference clocks; register read data is valid one cycle after
//          the read strobe.
// Notes:   All pins are oversampled by the reference clock.
//
// How it works
// RL1: Port works only with upper strap high and lower strap low.
// RL2: Chip select low starts a transaction; chip select high resets the port.
// RL3: Serial input is shifted in on each rising serial clock edge.
// RL4: Serial output advances to the next bit after each falling edge.
// RL5: Eight clocks per byte; after eighth falling edge next byte is loaded.
// RL6: Bytes travel most significant bit first in both directions.
// RL7: First byte holds command in bits 7:6 and address in bits 5:0.
// RL8: Read fetches the register and sends it during the next byte.
// RL9: No-operation touches no register and keeps clear-on-read bits intact.
// RL10: Single write takes command byte then data byte, written at its end.
// RL11: Burst write keeps writing data bytes to one address until deselect.
// RL12: Each write is read back without clearing and sent next byte.
// RL13: Read-back after a transmit data write is undefined to the host.
// RL14: Deselect drops any partial byte and clears the bit counter.
// RL15: Serial output is driven only while chip select is low.
`timescale 1ns/1ps
module hsp_port
	import hsp_pkg::*;
(
	input  wire logic              ref_clk_in,
	input  wire logic              rst_b_in,
	input  wire logic              interface_select_hi_in,
	input  wire logic              interface_select_lo_in,
	input  wire logic              cs_b_in,
	input  wire logic              serial_clock_in,
	input  wire logic              serial_data_in,
	output logic                   serial_data_out,
	output logic                   serial_data_oe_out,
	output logic                   port_active_out,
	output logic      [ADDR_W-1:0] reg_addr_out,
	output logic      [DATA_W-1:0] reg_wdata_out,
	output logic                   reg_wr_out,
	output logic                   reg_rd_out,
	output logic                   reg_rd_clear_out,
	input  wire logic [DATA_W-1:0] reg_rdata_in
);

	logic [SYNC_W-1:0] pins_s;
	logic              si_s;
	logic              sclk_s;
	logic              cs_s;
	logic              sclk_prev;
	logic              sclk_rise;
	logic              sclk_fall;
	logic              byte_done;
	logic [DATA_W-1:0] new_byte;

	logic [DATA_W-1:0] rx_shift;
	logic [DATA_W-1:0] tx_shift;
	logic [DATA_W-1:0] read_hold;
	logic [CNT_W-1:0]  bit_cnt;
	logic [CMD_W-1:0]  cmd_q;
	hsp_phase_t        phase;
	hsp_acc_t          acc;

	logic [DATA_W-1:0] next_rx_shift;
	logic [DATA_W-1:0] next_tx_shift;
	logic [DATA_W-1:0] next_read_hold;
	logic [CNT_W-1:0]  next_bit_cnt;
	logic [CMD_W-1:0]  next_cmd_q;
	hsp_phase_t        next_phase;
	hsp_acc_t          next_acc;
	logic              next_port_active;
	logic              next_oe;
	logic [ADDR_W-1:0] next_addr;
	logic [DATA_W-1:0] next_wdata;
	logic              next_wr;
	logic              next_rd;
	logic              next_rd_clear;

	hsp_sync u_sync (
		.ref_clk_in (ref_clk_in),
		.rst_b_in   (rst_b_in),
		.async_in   ({interface_select_hi_in, interface_select_lo_in,
		              cs_b_in, serial_clock_in, serial_data_in}),
		.sync_out   (pins_s)
	);

	assign si_s     = pins_s[SY_SI];
	assign sclk_s   = pins_s[SY_SCLK];
	assign cs_s     = pins_s[SY_CS];
	// Both edges come from the same synchronised copy, so data sampled at a
	// rising edge is always aligned with the clock seen by the counter.
	assign sclk_rise = sclk_s & ~sclk_prev;
	assign sclk_fall = ~sclk_s & sclk_prev;
	assign new_byte = {rx_shift[DATA_W-2:0], si_s}; // RL6
	assign byte_done = sclk_rise && (bit_cnt == BIT_LAST) && !cs_s
	                   && port_active_out;

	always_comb begin
		next_rx_shift    = rx_shift;
		next_tx_shift    = tx_shift;
		next_read_hold   = read_hold;
		next_bit_cnt     = bit_cnt;
		next_cmd_q       = cmd_q;
		next_phase       = phase;
		next_acc         = acc;
		next_addr        = reg_addr_out;
		next_wdata       = reg_wdata_out;
		next_wr          = 1'b0;
		next_rd          = 1'b0;
		next_rd_clear    = 1'b0;
		next_port_active = pins_s[SY_HI] & ~pins_s[SY_LO]; // RL1
		next_oe          = next_port_active & ~cs_s; // RL15

		// Register access sequencer; it runs to completion even if the
		// host deselects, so the fetched value is kept for next time.
		case (acc)
			ACC_WB: begin
				next_rd  = 1'b1; // RL12
				next_acc = ACC_RD;
			end
			ACC_RD: begin
				next_acc = ACC_CAPT;
			end
			ACC_CAPT: begin
				next_read_hold = reg_rdata_in; // RL13
				next_acc       = ACC_IDLE;
			end
			default: begin
				next_acc = ACC_IDLE;
			end
		endcase

		if (cs_s || !port_active_out) begin
			next_bit_cnt  = '0; // RL14
			next_rx_shift = DATA_RST; // RL14
			next_phase    = PH_CMD; // RL2
			next_tx_shift = read_hold; // RL8
		end else begin
			if (sclk_rise && bit_cnt != BITS_BYTE) begin
				next_rx_shift = new_byte; // RL3
				next_bit_cnt  = bit_cnt + 4'h1;
			end
			if (sclk_fall && bit_cnt == BITS_BYTE) begin
				next_bit_cnt  = '0; // RL5
				next_tx_shift = read_hold; // RL5
			end else if (sclk_fall && bit_cnt != '0) begin
				next_tx_shift = {tx_shift[DATA_W-2:0], 1'b0}; // RL4
			end
			if (byte_done && phase == PH_CMD) begin
				next_cmd_q = new_byte[CMD_MSB:CMD_LSB]; // RL7
				next_addr  = new_byte[ADDR_MSB:0]; // RL7
				case (new_byte[CMD_MSB:CMD_LSB])
					CMD_READ: begin
						next_rd       = 1'b1; // RL8
						next_rd_clear = 1'b1;
						next_acc      = ACC_RD;
					end
					CMD_WRITE, CMD_BURST: begin
						next_phase = PH_DATA; // RL10
					end
					default: begin
						next_phase = PH_CMD; // RL9
					end
				endcase
			end else if (byte_done) begin
				next_wdata = new_byte; // RL10
				next_wr    = 1'b1;
				next_acc   = ACC_WB; // RL12
				if (cmd_q == CMD_BURST) begin
					next_phase = PH_DATA; // RL11
				end else begin
					next_phase = PH_CMD; // RL10
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sclk_prev          <= 1'b0;
			rx_shift           <= DATA_RST;
			tx_shift           <= DATA_RST;
			read_hold          <= DATA_RST;
			bit_cnt            <= '0;
			cmd_q              <= CMD_NOP;
			phase              <= PH_CMD;
			acc                <= ACC_IDLE;
			port_active_out    <= 1'b0;
			serial_data_oe_out <= 1'b0;
			serial_data_out    <= 1'b0;
			reg_addr_out       <= ADDR_RST;
			reg_wdata_out      <= DATA_RST;
			reg_wr_out         <= 1'b0;
			reg_rd_out         <= 1'b0;
			reg_rd_clear_out   <= 1'b0;
		end else begin
			sclk_prev          <= sclk_s;
			rx_shift           <= next_rx_shift;
			tx_shift           <= next_tx_shift;
			read_hold          <= next_read_hold;
			bit_cnt            <= next_bit_cnt;
			cmd_q              <= next_cmd_q;
			phase              <= next_phase;
			acc                <= next_acc;
			port_active_out    <= next_port_active;
			serial_data_oe_out <= next_oe;
			serial_data_out    <= next_tx_shift[DATA_W-1]; // RL6
			reg_addr_out       <= next_addr;
			reg_wdata_out      <= next_wdata;
			reg_wr_out         <= next_wr;
			reg_rd_out         <= next_rd;
			reg_rd_clear_out   <= next_rd_clear;
		end
	end

	// Checks of the port behaviour against the synchronised pin view.
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_b_in);

	property p_strap_gate;
		serial_data_oe_out |-> port_active_out;
	endproperty
	a_strap_gate: assert property (p_strap_gate) // RL1
		else $error("Output enabled while port inactive.");

	property p_deselect;
		cs_s |=> (bit_cnt == '0) && (phase == PH_CMD) && (rx_shift == '0);
	endproperty
	a_deselect: assert property (p_deselect) // RL14
		else $error("Deselect did not reset the port.");

	property p_sample;
		sclk_rise && !cs_s && port_active_out && bit_cnt != BITS_BYTE
		|=> rx_shift == {$past(rx_shift[DATA_W-2:0]), $past(si_s)};
	endproperty
	a_sample: assert property (p_sample) // RL3
		else $error("Serial input not shifted in on rising edge.");

	property p_out_change;
		$changed(serial_data_out)
		|-> $past(sclk_fall || cs_s || !port_active_out);
	endproperty
	a_out_change: assert property (p_out_change) // RL4
		else $error("Serial output changed away from a falling edge.");

	property p_byte_load;
		sclk_fall && bit_cnt == BITS_BYTE && !cs_s && port_active_out
		|=> bit_cnt == '0 ##0 tx_shift == $past(read_hold);
	endproperty
	a_byte_load: assert property (p_byte_load) // RL5
		else $error("Next byte not loaded after eighth falling edge.");

	property p_read_cmd;
		byte_done && phase == PH_CMD && new_byte[CMD_MSB:CMD_LSB] == CMD_READ
		|=> reg_rd_out && reg_rd_clear_out
		    && reg_addr_out == $past(new_byte[ADDR_MSB:0])
		##2 read_hold == $past(reg_rdata_in);
	endproperty
	a_read_cmd: assert property (p_read_cmd) // RL8
		else $error("Read command did not fetch the register.");

	property p_nop_cmd;
		byte_done && phase == PH_CMD && new_byte[CMD_MSB:CMD_LSB] == CMD_NOP
		|=> (!reg_rd_out && !reg_wr_out && phase == PH_CMD) [*3];
	endproperty
	a_nop_cmd: assert property (p_nop_cmd) // RL9
		else $error("No-operation touched the register file.");

	property p_single_write;
		byte_done && phase == PH_DATA && cmd_q == CMD_WRITE
		|=> reg_wr_out && reg_wdata_out == $past(new_byte)
		    && phase == PH_CMD;
	endproperty
	a_single_write: assert property (p_single_write) // RL10
		else $error("Single write not performed at end of data byte.");

	property p_burst_write;
		byte_done && phase == PH_DATA && cmd_q == CMD_BURST
		|=> reg_wr_out && $stable(reg_addr_out) && phase == PH_DATA;
	endproperty
	a_burst_write: assert property (p_burst_write) // RL11
		else $error("Burst write left the data phase or moved address.");

	property p_readback;
		reg_wr_out |=> reg_rd_out && !reg_rd_clear_out
		               && $stable(reg_addr_out);
	endproperty
	a_readback: assert property (p_readback) // RL12
		else $error("Write not followed by a plain read-back.");

	property p_oe_cs;
		serial_data_oe_out |-> $past(!cs_s);
	endproperty
	a_oe_cs: assert property (p_oe_cs) // RL15
		else $error("Serial output driven while deselected.");

	c_read: cover property (byte_done && phase == PH_CMD
		&& new_byte[CMD_MSB:CMD_LSB] == CMD_READ);
	c_nop: cover property (byte_done && phase == PH_CMD
		&& new_byte[CMD_MSB:CMD_LSB] == CMD_NOP);
	c_write: cover property (reg_wr_out && cmd_q == CMD_WRITE);
	c_burst: cover property (reg_wr_out && cmd_q == CMD_BURST
		##[1:200] reg_wr_out);

endmodule : hsp_port

// file: core/hsp_pkg.sv
// Purpose: Shared constants and types for the serial host register port.
// Assumes: Register addresses are 6 bits and register data is 8 bits.
// Notes:   Command codes sit in the top two bits of the first byte.
package hsp_pkg;

	localparam int          ADDR_W      = 6;
	localparam int          DATA_W      = 8;
	localparam int          CMD_W       = 2;
	localparam int          CNT_W       = 4;
	localparam logic [3:0]  BITS_BYTE   = 4'h8;
	localparam logic [3:0]  BIT_LAST    = 4'h7;
	localparam int          CMD_MSB     = 7;
	localparam int          CMD_LSB     = 6;
	localparam int          ADDR_MSB    = 5;

	localparam logic [1:0]  CMD_READ    = 2'h0;
	localparam logic [1:0]  CMD_NOP     = 2'h1;
	localparam logic [1:0]  CMD_WRITE   = 2'h2;
	localparam logic [1:0]  CMD_BURST   = 2'h3;

	localparam logic [7:0]  DATA_RST    = 8'h00;
	localparam logic [5:0]  ADDR_RST    = 6'h00;

	// Bit positions inside the synchroniser vector.
	localparam int          SYNC_W      = 5;
	localparam int          SY_SI       = 0;
	localparam int          SY_SCLK     = 1;
	localparam int          SY_CS       = 2;
	localparam int          SY_LO       = 3;
	localparam int          SY_HI       = 4;

	typedef enum logic [0:0] {
		PH_CMD  = 1'b0,
		PH_DATA = 1'b1
	} hsp_phase_t;

	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_WB   = 2'b01,
		ACC_RD   = 2'b10,
		ACC_CAPT = 2'b11
	} hsp_acc_t;

endpackage : hsp_pkg

// file: core/hsp_sync.sv
// Purpose: Two-flop synchroniser for the pins of the serial host port.
// Assumes: Each bit is an independent level from outside the clock domain.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module hsp_sync
	import hsp_pkg::*;
(
	input  wire logic              ref_clk_in,
	input  wire logic              rst_b_in,
	input  wire logic [SYNC_W-1:0] async_in,
	output logic      [SYNC_W-1:0] sync_out
);

	logic [SYNC_W-1:0] stage1;

	genvar g;
	generate
		for (g = 0; g < SYNC_W; g++) begin : g_bit
			always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					stage1[g]   <= 1'b0;
					sync_out[g] <= 1'b0;
				end else begin
					stage1[g]   <= async_in[g];
					sync_out[g] <= stage1[g];
				end
			end
		end
	endgenerate

endmodule : hsp_sync

// file: verif/hsp_host_model.sv
// Purpose: Behavioural serial host that clocks bytes through the port.
// Assumes: Serial clock idles low; one bit takes eight reference clocks.
// Notes:   Signals change only at falling reference clock edges.
`timescale 1ns/1ps
module hsp_host_model
	import hsp_pkg::*;
(
	input  wire logic ref_clk_in,
	input  wire logic so_in,
	input  wire logic so_oe_in,
	output logic      cs_b_out,
	output logic      sclk_out,
	output logic      si_out
);
	logic last_bit;

	initial begin
		cs_b_out = 1'b1;
		sclk_out = 1'b0;
		si_out   = 1'b0;
		last_bit = 1'b0;
	end

	// Outside frames the data line toggles so no stale bit looks valid.
	always @(negedge ref_clk_in) begin
		if (cs_b_out) begin
			si_out <= ~si_out;
		end
	end

	task wait_clk(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask : wait_clk

	task sel();
		@(negedge ref_clk_in);
		cs_b_out = 1'b0;
		wait_clk(6);
	endtask : sel

	task desel();
		cs_b_out = 1'b1;
		wait_clk(8);
	endtask : desel

	// A gap after each byte leaves time for the register fetch.
	task xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 0; i < nbits; i++) begin
			si_out = tx[7-i];
			wait_clk(4);
			sclk_out = 1'b1;
			rx = {rx[6:0], so_oe_in ? so_in : ~last_bit};
			last_bit = rx[0];
			wait_clk(4);
			sclk_out = 1'b0;
		end
		wait_clk(8);
	endtask : xfer
endmodule : hsp_host_model

// file: verif/tb_top.sv
// Purpose: Self-checking bench for the serial host register port.
// Assumes: Register file answers one cycle after the read strobe.
// Notes:   Expected data comes from a shadow copy kept by the bench.
`timescale 1ns/1ps
module tb_top
	import hsp_pkg::*;
;
	logic              ref_clk_in, rst_b_in, sel_hi, sel_lo;
	logic              cs_b, sclk, si, so, so_oe, active, wr, rd, rd_clr;
	logic [ADDR_W-1:0] addr, a, b;
	logic [DATA_W-1:0] wdata, rdata, rx, held, d;
	logic [DATA_W-1:0] mem [64];
	logic [DATA_W-1:0] exp_mem [64];
	int                errors, n_tests, n_wr, n_clr, x_wr, x_clr;

	hsp_port DUT (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.interface_select_hi_in(sel_hi), .interface_select_lo_in(sel_lo),
		.cs_b_in(cs_b), .serial_clock_in(sclk), .serial_data_in(si),
		.serial_data_out(so), .serial_data_oe_out(so_oe),
		.port_active_out(active), .reg_addr_out(addr),
		.reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd),
		.reg_rd_clear_out(rd_clr), .reg_rdata_in(rdata));

	hsp_host_model HOST (.ref_clk_in(ref_clk_in), .so_in(so),
		.so_oe_in(so_oe), .cs_b_out(cs_b), .sclk_out(sclk), .si_out(si));

	always #20 ref_clk_in = ~ref_clk_in;

	always @(negedge ref_clk_in) begin
		if (wr === 1'b1) mem[addr] <= wdata;
		if (rd === 1'b1) rdata <= mem[addr];
		n_wr  += (wr === 1'b1);
		n_clr += (rd === 1'b1 && rd_clr === 1'b1);
	end

	task test_done();
		$display("errors %0d tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done

	task chk(input string name, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	task op(input logic [7:0] tx, input logic [7:0] e, input string name);
		HOST.xfer(tx, 8, rx);
		chk(name, e, rx);
	endtask : op

	function automatic logic [7:0] cmd(input logic [1:0] c, input logic [5:0] ad);
		return {c, ad};
	endfunction : cmd

	task read_back(input logic [5:0] ad);
		op(cmd(CMD_READ, ad), held, "read cmd");
		op(cmd(CMD_NOP, 6'h00), exp_mem[ad], "read data");
		held = exp_mem[ad];
		x_clr++;
	endtask : read_back

	initial begin
		#2000000;
		errors++;
		test_done();
	end

	initial begin
		ref_clk_in = 1'b0;
		rst_b_in = 1'b0;
		sel_hi = 1'b1;
		sel_lo = 1'b0;
		rdata = 8'h00;
		for (int i = 0; i < 64; i++) begin
			mem[i] = 8'h00;
			exp_mem[i] = 8'h00;
		end
		void'($urandom(32'h141c));
		repeat (3) @(negedge ref_clk_in);
		rst_b_in = 1'b1;
		HOST.wait_clk(5);
		held = DATA_RST;
		for (int i = 0; i < 8; i++) begin
			a = 6'($urandom);
			b = (i == 0) ? 6'h3f : 6'($urandom);
			d = (i == 1) ? 8'hff : 8'($urandom);
			HOST.sel();
			chk("oe while selected", 8'h01, {7'h00, so_oe});
			op(cmd(CMD_WRITE, a), held, "write cmd");
			op(d, held, "write data");
			exp_mem[a] = d;
			x_wr++;
			op(cmd(CMD_NOP, a), d, "write readback");
			held = d;
			read_back(b);
			HOST.desel();
			chk("oe after deselect", 8'h00, {7'h00, so_oe});
		end
		HOST.sel();
		op(cmd(CMD_BURST, a), held, "burst cmd");
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			op(d, held, "burst data");
			held = d;
			x_wr++;
		end
		exp_mem[a] = held;
		HOST.desel();
		HOST.sel();
		read_back(a);
		HOST.desel();
		// A cut-off burst command must not survive the deselect.
		HOST.sel();
		HOST.xfer(8'hff, 5, rx);
		HOST.desel();
		HOST.sel();
		read_back(b);
		HOST.desel();
		sel_lo = 1'b1;
		HOST.wait_clk(6);
		chk("port active", 8'h00, {7'h00, active});
		HOST.sel();
		chk("oe wrong straps", 8'h00, {7'h00, so_oe});
		HOST.xfer(cmd(CMD_WRITE, a), 8, rx);
		HOST.xfer(8'h5a, 8, rx);
		HOST.desel();
		sel_lo = 1'b0;
		HOST.wait_clk(6);
		chk("write strobes", 8'(x_wr), 8'(n_wr));
		chk("clearing reads", 8'(x_clr), 8'(n_clr));
		test_done();
	end
endmodule : tb_top
